/* inc/reset_seq_pkg.sv */
// constants and types shared by the reset sequencer files
package reset_seq_pkg;

    localparam int CLOCK_HZ       = 40_000_000;
    localparam int US_TICK_CYCLES = CLOCK_HZ / 1_000_000;

    // power-on hold, typical figure, in 1 us ticks
    localparam int POR_DELAY_MS   = 10;
    localparam int POR_DELAY_US   = POR_DELAY_MS * 1000;

    // release delay for every source other than power-on
    localparam int RST_DELAY_US     = 50;
    localparam int RST_DELAY_CYCLES = RST_DELAY_US * US_TICK_CYCLES;

    // missing clock trigger frequency, in tenths of kHz (7.5 kHz)
    localparam int MCD_TRIG_KHZ_X10 = 75;
    localparam int MCD_GAP_CYCLES   =
        (CLOCK_HZ * 10) / (MCD_TRIG_KHZ_X10 * 1000);

    // pin reads are ignored this long after the device stops driving it
    localparam logic [1:0] PIN_BLANK_CYCLES = 2'h3;

    localparam logic [7:0]  BOOT_SIGNATURE = 8'ha5;
    localparam logic [15:0] RESET_VECTOR   = 16'h0000;

    // port defaults: latch value, open-drain, weak pull-up
    localparam logic [2:0] PORT_DEFAULTS = 3'h7;

    localparam int NUM_SOURCES = 8;
    localparam int SRC_POR     = 0;
    localparam int SRC_PIN     = 1;
    localparam int SRC_CMP     = 2;
    localparam int SRC_SW      = 3;
    localparam int SRC_SUPPLY  = 4;
    localparam int SRC_WDT     = 5;
    localparam int SRC_MCD     = 6;
    localparam int SRC_FLASH   = 7;

    typedef enum logic [1:0] {
        ST_HOLD  = 2'b00,
        ST_DELAY = 2'b01,
        ST_START = 2'b11,
        ST_RUN   = 2'b10
    } seq_state_t;

endpackage

/* rtl/us_tick_divider.sv */
// divider that yields a one-cycle enable pulse every DIVIDE clocks
module us_tick_divider
    import reset_seq_pkg::*;
#(
    parameter int DIVIDE = US_TICK_CYCLES
)(
    input  wire logic clock,
    input  wire logic reset,
    output logic      tick
);

    typedef struct packed {
        logic [15:0] count;
        logic        tick;
    } div_regs_t;

    div_regs_t q;
    div_regs_t d;

    if (DIVIDE < 2 || DIVIDE > 65535)
    begin
        $error("us_tick_divider: DIVIDE out of range");
    end

    always_comb
    begin
        d = q;
        d.tick = (q.count == 16'h0000);
        if (q.count == 16'h0000)
            d.count = 16'(DIVIDE - 1);
        else
            d.count = q.count - 16'h0001;
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            q <= '0;
        else
            q <= d;
    end

    assign tick = q.tick;

endmodule

/* rtl/system_reset_sequencer.sv */
// reset source collection, hold and release sequencing
module system_reset_sequencer
    import reset_seq_pkg::*;
#(
    parameter int          POR_TICKS   = POR_DELAY_US,
    parameter int          MCD_GAP     = MCD_GAP_CYCLES,
    parameter logic [15:0] BOOT_VECTOR = 16'hfc00
)(
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        power_good_async,
    input  wire logic        supply_ok_async,
    input  wire logic        external_reset_pin_n,
    input  wire logic        core_clock_toggle_async,
    input  wire logic        comparator_reset_req,
    input  wire logic        software_reset_req,
    input  wire logic        watchdog_timeout,
    input  wire logic        flash_error,
    input  wire logic        missing_clock_enable,
    input  wire logic        retention_enable,
    input  wire logic [7:0]  bootloader_signature,
    output logic             core_halt,
    output logic             module_reset,
    output logic             por_only_reset,
    output logic             port_force_safe,
    output logic             port_latch_value,
    output logic             port_open_drain,
    output logic             port_weak_pullup,
    output logic             analog_hold,
    output logic             interrupts_timers_off,
    output logic             ram_write_block,
    output logic             reset_pin_out,
    output logic             reset_pin_oe_n,
    output logic             pc_clear,
    output logic             clock_select_internal,
    output logic             watchdog_enable,
    output logic             fetch_start,
    output logic [15:0]      fetch_vector,
    output logic [7:0]       reset_cause
);

    localparam int SYNC_PG  = 0;
    localparam int SYNC_SOK = 1;
    localparam int SYNC_PIN = 2;
    localparam int SYNC_CLK = 3;

    typedef struct packed {
        seq_state_t  st;
        logic [15:0] cnt;
        logic [15:0] mcd_cnt;
        logic [1:0]  blank;
        logic        por;
        logic [3:0]  sync1;
        logic [3:0]  sync2;
        logic        clk_prev;
        logic [7:0]  cause;
        logic        halt;
        logic        mod_rst;
        logic        por_rst;
        logic        force_safe;
        logic        hold_analog;
        logic        irq_off;
        logic        ram_block;
        logic        pin_oe_n;
        logic        pc_clr;
        logic        clk_int;
        logic        wdt_en;
        logic        fetch;
        logic [2:0]  port_def;
        logic [15:0] vector;
    } regs_t;

    localparam regs_t REGS_RESET = '{
        st:          ST_HOLD,
        por:         1'b1,
        sync1:       4'h4,
        sync2:       4'h4,
        cause:       8'h01,
        halt:        1'b1,
        mod_rst:     1'b1,
        por_rst:     1'b1,
        force_safe:  1'b1,
        irq_off:     1'b1,
        ram_block:   1'b1,
        clk_int:     1'b1,
        port_def:    PORT_DEFAULTS,
        vector:      RESET_VECTOR,
        default:     '0
    };

    // a full tick count: the first tick may come right after loading
    localparam logic [15:0] POR_LOAD = 16'(POR_TICKS);
    localparam logic [15:0] RST_LOAD = 16'(RST_DELAY_CYCLES - 1);
    localparam logic [15:0] MCD_LIM  = 16'(MCD_GAP);

    if (POR_TICKS < 1 || POR_TICKS > 65535)
    begin
        $error("system_reset_sequencer: POR_TICKS out of range");
    end
    if (MCD_GAP < 2 || MCD_GAP > 65535)
    begin
        $error("system_reset_sequencer: MCD_GAP out of range");
    end

    regs_t                  q;
    regs_t                  d;
    logic                   tick;
    logic [NUM_SOURCES-1:0] src;
    logic                   any_src;
    logic                   pin_mask;
    logic                   clk_edge;
    logic                   mcd_trip;
    logic                   step;
    logic                   keep;
    logic                   halt_d;

    // time base for the long power-on hold
    us_tick_divider #(
        .DIVIDE (US_TICK_CYCLES)
    ) u_tick (
        .clock  (clock),
        .reset  (reset),
        .tick   (tick)
    );

    always_comb
    begin
        d = q;

        // pad-side levels pass two flops before use
        d.sync1 = {core_clock_toggle_async, external_reset_pin_n,
                   supply_ok_async, power_good_async};
        d.sync2 = q.sync1;
        d.clk_prev = q.sync2[SYNC_CLK];
        clk_edge = q.sync2[SYNC_CLK] ^ q.clk_prev;

        // own drive of the pin and its settling must not re-trigger
        pin_mask = ~q.pin_oe_n | (q.blank != 2'h0);

        // missing clock: no core clock edge for a trigger period
        mcd_trip = (q.mcd_cnt == MCD_LIM);
        if (q.st != ST_RUN || !missing_clock_enable || clk_edge)
            d.mcd_cnt = 16'h0000;
        else if (!mcd_trip)
            d.mcd_cnt = q.mcd_cnt + 16'h0001;

        src[SRC_POR]    = ~q.sync2[SYNC_PG];
        src[SRC_PIN]    = ~q.sync2[SYNC_PIN] & ~pin_mask;
        src[SRC_CMP]    = comparator_reset_req;
        src[SRC_SW]     = software_reset_req;
        src[SRC_SUPPLY] = ~q.sync2[SYNC_SOK];
        src[SRC_WDT]    = watchdog_timeout;
        src[SRC_MCD]    = mcd_trip;
        src[SRC_FLASH]  = flash_error;
        any_src = |src;

        // power-on hold steps in microseconds, the others in cycles
        step = q.por ? tick : 1'b1;

        case (q.st)
            ST_HOLD:
            begin
                if (!any_src)
                begin
                    d.st = ST_DELAY;
                    d.cnt = q.por ? POR_LOAD : RST_LOAD;
                end
            end
            ST_DELAY:
            begin
                if (any_src)
                    d.st = ST_HOLD;
                else if (q.cnt == 16'h0000)
                    d.st = ST_START;
                else if (step)
                    d.cnt = q.cnt - 16'h0001;
            end
            ST_START:
            begin
                if (any_src)
                    d.st = ST_HOLD;
                else
                    d.st = ST_RUN;
            end
            ST_RUN:
            begin
                if (any_src)
                    d.st = ST_HOLD;
            end
            default:
            begin
                d.st = ST_HOLD;
            end
        endcase

        d.por = (q.por & (d.st != ST_RUN)) | src[SRC_POR];

        // causes of the current reset; a new entry from run starts over
        if (q.st == ST_RUN && any_src)
            d.cause = src;
        else
            d.cause = q.cause | src;

        halt_d = (d.st == ST_HOLD) || (d.st == ST_DELAY);
        keep = retention_enable & ~d.por;

        d.halt = halt_d;
        d.mod_rst = halt_d;
        d.por_rst = halt_d & d.por;
        d.force_safe = halt_d & ~keep;
        d.hold_analog = halt_d & keep;
        d.irq_off = halt_d;
        // core writes are blocked, RAM itself is never cleared
        d.ram_block = halt_d;
        d.port_def = PORT_DEFAULTS;
        d.pin_oe_n = ~(halt_d & (d.por | d.cause[SRC_SUPPLY]));

        if (!d.pin_oe_n)
            d.blank = PIN_BLANK_CYCLES;
        else if (q.blank != 2'h0)
            d.blank = q.blank - 2'h1;

        d.pc_clr = (d.st == ST_START);
        d.clk_int = halt_d | (d.st == ST_START);
        d.wdt_en = (d.st == ST_START);
        d.fetch = (d.st == ST_START);
        if (d.st == ST_START)
        begin
            if (bootloader_signature == BOOT_SIGNATURE)
                d.vector = BOOT_VECTOR;
            else
                d.vector = RESET_VECTOR;
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            q <= REGS_RESET;
        else
            q <= d;
    end

    assign core_halt             = q.halt;
    assign module_reset          = q.mod_rst;
    assign por_only_reset        = q.por_rst;
    assign port_force_safe       = q.force_safe;
    assign port_latch_value      = q.port_def[2];
    assign port_open_drain       = q.port_def[1];
    assign port_weak_pullup      = q.port_def[0];
    assign analog_hold           = q.hold_analog;
    assign interrupts_timers_off = q.irq_off;
    assign ram_write_block       = q.ram_block;
    assign reset_pin_out         = q.pin_oe_n;
    assign reset_pin_oe_n        = q.pin_oe_n;
    assign pc_clear              = q.pc_clr;
    assign clock_select_internal = q.clk_int;
    assign watchdog_enable       = q.wdt_en;
    assign fetch_start           = q.fetch;
    assign fetch_vector          = q.vector;
    assign reset_cause           = q.cause;

    // cycles spent in the release delay, for the checks below
    logic [31:0] dly_obs_q;

    always_ff @(posedge clock)
    begin
        if (reset)
            dly_obs_q <= '0;
        else if (q.st == ST_DELAY)
            dly_obs_q <= dly_obs_q + 32'h1;
        else if (q.st != ST_START)
            dly_obs_q <= '0;
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    sequence exit_s;
        core_halt ##1 !core_halt;
    endsequence

    sequence drive_s;
        !reset_pin_oe_n && !reset_pin_out;
    endsequence

    source_halts_a: assert property (any_src |=> core_halt)
        else $error("reset source did not halt the core");

    regs_reset_a: assert property (core_halt |-> module_reset &&
        interrupts_timers_off && ram_write_block)
        else $error("reset defaults not applied while halted");

    port_defaults_a: assert property (core_halt && por_only_reset
        |-> port_force_safe && port_latch_value && port_open_drain
        && port_weak_pullup && !analog_hold)
        else $error("ports not safe during power-on reset");

    retention_a: assert property (core_halt && !por_only_reset
        && $past(retention_enable) |-> !port_force_safe && analog_hold)
        else $error("retention ignored on non power-on reset");

    pin_drive_a: assert property (por_only_reset |-> drive_s)
        else $error("reset pin not driven during power-on reset");

    pin_release_a: assert property (!core_halt |-> reset_pin_oe_n)
        else $error("reset pin driven outside reset");

    exit_steps_a: assert property (exit_s |-> pc_clear &&
        watchdog_enable && fetch_start && clock_select_internal
        ##1 !pc_clear && !fetch_start)
        else $error("exit from reset missing its one-cycle steps");

    vector_pick_a: assert property (fetch_start |-> fetch_vector ==
        (($past(bootloader_signature) == BOOT_SIGNATURE) ?
        BOOT_VECTOR : RESET_VECTOR))
        else $error("wrong start vector");

    short_delay_a: assert property (q.st == ST_START && !q.por
        |-> dly_obs_q == 32'(RST_DELAY_CYCLES))
        else $error("release delay not 50 us");

    por_delay_a: assert property (q.st == ST_START && q.por
        |-> dly_obs_q > 32'((POR_TICKS - 1) * US_TICK_CYCLES))
        else $error("power-on delay too short");

    mcd_trip_a: assert property (q.st == ST_RUN && missing_clock_enable
        && q.mcd_cnt == MCD_LIM |=> core_halt && reset_cause[SRC_MCD])
        else $error("missing clock did not reset");

endmodule

/* verif/reset_pin_partner.sv */
// supply monitors, monitored clock and outside reset driver model
module reset_pin_partner
    import reset_seq_pkg::*;
#(
    parameter int PIN_LOW_CYCLES = 15 * US_TICK_CYCLES
)(
    input  wire logic clock,
    input  wire logic power_drop,
    input  wire logic supply_drop,
    input  wire logic pin_request,
    input  wire logic clock_stop,
    input  wire logic reset_pin_oe_n,
    input  wire logic reset_pin_out,
    output logic      power_good_async,
    output logic      supply_ok_async,
    output logic      external_reset_pin_n,
    output logic      core_clock_toggle_async
);
    timeunit 1ns;
    timeprecision 1ps;

    int   low_count = 0;
    logic stretch;

    assign power_good_async = !power_drop;
    assign supply_ok_async  = !supply_drop;
    // pulled up: low while either side pulls it down
    assign external_reset_pin_n =
        !(pin_request || stretch || (!reset_pin_oe_n && !reset_pin_out));
    // a short request is still held for the minimum low time
    assign stretch = low_count != 0 && low_count < PIN_LOW_CYCLES;

    always @(posedge clock)
        low_count <= (pin_request || stretch) ? low_count + 1 : 0;

    initial
        core_clock_toggle_async = 1'b0;

    // monitored clock stands still while stopped
    always @(negedge clock)
        if (!clock_stop)
            core_clock_toggle_async <= ~core_clock_toggle_async;
endmodule

/* verif/system_reset_sequencer_bench.sv */
// self-checking bench for the reset sequencer
module system_reset_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import reset_seq_pkg::*;

    localparam int POR_T = 5;
    localparam int MCD_T = 20;

    logic clock, reset, power_drop, supply_drop, pin_request, clock_stop;
    logic cmp_req, sw_req, wdt_req, flash_req, mcd_en, ret_en;
    logic [7:0] sig, reset_cause;
    logic power_good_async, supply_ok_async;
    logic external_reset_pin_n, core_clock_toggle_async;
    logic core_halt, module_reset, por_only_reset, port_force_safe;
    logic port_latch_value, port_open_drain, port_weak_pullup, analog_hold;
    logic interrupts_timers_off, ram_write_block, reset_pin_out;
    logic reset_pin_oe_n, pc_clear, clock_select_internal;
    logic watchdog_enable, fetch_start;
    logic [15:0] fetch_vector;
    logic [31:0] seed;
    int fail_count, checked, n, lo, hi;
    int order[8] = '{1, 2, 3, 4, 5, 7, 6, 0};

    system_reset_sequencer #(
        .POR_TICKS(POR_T),
        .MCD_GAP  (MCD_T)
    ) DUT (
        .clock, .reset, .power_good_async, .supply_ok_async,
        .external_reset_pin_n, .core_clock_toggle_async,
        .comparator_reset_req(cmp_req), .software_reset_req(sw_req),
        .watchdog_timeout(wdt_req), .flash_error(flash_req),
        .missing_clock_enable(mcd_en), .retention_enable(ret_en),
        .bootloader_signature(sig), .core_halt, .module_reset,
        .por_only_reset, .port_force_safe, .port_latch_value,
        .port_open_drain, .port_weak_pullup, .analog_hold,
        .interrupts_timers_off, .ram_write_block, .reset_pin_out,
        .reset_pin_oe_n, .pc_clear, .clock_select_internal,
        .watchdog_enable, .fetch_start, .fetch_vector, .reset_cause
    );

    reset_pin_partner partner (
        .clock, .power_drop, .supply_drop, .pin_request, .clock_stop,
        .reset_pin_oe_n, .reset_pin_out, .power_good_async,
        .supply_ok_async, .external_reset_pin_n, .core_clock_toggle_async
    );

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [15:0] vector_for(input logic [7:0] s);
        return (s === BOOT_SIGNATURE) ? 16'hfc00 : RESET_VECTOR;
    endfunction

    task automatic check_bit(input logic got, input logic exp, string w);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: %s got %b", $time, w, got);
        end
    endtask

    task automatic check_vec(input logic [15:0] got, exp, input string w);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: %s got %h", $time, w, got);
        end
    endtask

    task automatic check_count(input int got, lo, hi, input string w);
        checked++;
        if (got < lo || got > hi)
        begin
            fail_count++;
            $display("mismatch at %0t: %s took %0d", $time, w, got);
        end
    endtask

    task automatic tally_and_finish;
        if (fail_count == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // counts falling edges until halt (0) or fetch start (1) is seen
    task automatic wait_on(input bit which, output int c);
        c = 0;
        do
        begin
            @(negedge clock);
            c++;
        end
        while ((which ? fetch_start : core_halt) !== 1'b1 && c < 6000);
    endtask

    task automatic set_source(input int s, input logic v);
        case (s)
            SRC_POR:    power_drop = v;
            SRC_PIN:    pin_request = v;
            SRC_CMP:    cmp_req = v;
            SRC_SW:     sw_req = v;
            SRC_SUPPLY: supply_drop = v;
            SRC_WDT:    wdt_req = v;
            SRC_MCD:    clock_stop = v;
            default:    flash_req = v;
        endcase
    endtask

    task automatic check_halt(input int s);
        logic por;
        por = (s == SRC_POR);
        check_bit(core_halt, 1'b1, "halt");
        check_bit(module_reset, 1'b1, "regs");
        check_bit(por_only_reset, por, "por regs");
        check_bit(port_force_safe, por | !ret_en, "safe");
        check_bit(analog_hold, !por & ret_en, "retain");
        check_bit(interrupts_timers_off, 1'b1, "irq");
        check_bit(ram_write_block, 1'b1, "ram");
        check_bit(port_latch_value & port_open_drain, 1'b1, "latch");
        check_bit(port_weak_pullup, 1'b1, "pullup");
        check_bit(reset_pin_oe_n, !(por | s == SRC_SUPPLY), "pin");
        check_bit(reset_pin_out, !(por | s == SRC_SUPPLY), "pin out");
        check_vec({8'h00, reset_cause}, 16'h0001 << s, "cause");
    endtask

    task automatic check_exit;
        check_bit(pc_clear, 1'b1, "pc");
        check_bit(clock_select_internal, 1'b1, "osc");
        check_bit(watchdog_enable, 1'b1, "wdt on");
        check_bit(core_halt, 1'b0, "run");
        check_bit(reset_pin_oe_n, 1'b1, "pin free");
        check_vec(fetch_vector, vector_for(sig), "vec");
        @(negedge clock);
        check_bit(fetch_start, 1'b0, "pulse");
        check_bit(clock_select_internal, 1'b0, "osc off");
    endtask

    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    initial
    begin
        repeat (40000) @(posedge clock);
        fail_count++;
        tally_and_finish;
    end

    initial
    begin
        {power_drop, supply_drop, pin_request, clock_stop} = '0;
        {cmp_req, sw_req, wdt_req, flash_req, mcd_en, ret_en} = '0;
        sig = 8'h00;
        seed = 32'h9cde;
        fail_count = 0;
        checked = 0;
        reset = 1'b1;
        repeat (6) @(negedge clock);
        check_halt(SRC_POR);
        reset = 1'b0;
        wait_on(1'b1, n);
        check_count(n, (POR_T - 1) * 40, POR_T * 40 + 12, "por");
        check_exit;
        foreach (order[i])
        begin
            seed = lfsr(seed);
            ret_en = seed[0];
            sig = i[0] ? BOOT_SIGNATURE : seed[15:8];
            if (order[i] == SRC_MCD)
            begin
                clock_stop = 1'b1;
                repeat (3 * MCD_T) @(negedge clock);
                check_bit(core_halt, 1'b0, "mcd off");
                clock_stop = 1'b0;
                mcd_en = 1'b1;
                repeat (4) @(negedge clock);
            end
            set_source(order[i], 1'b1);
            wait_on(1'b0, n);
            hi = order[i] == SRC_MCD ? MCD_T + 8 : 4;
            check_count(n, 1, hi, "entry");
            check_halt(order[i]);
            repeat (order[i] == SRC_MCD ? 0 : 600 + seed[21:16])
                @(negedge clock);
            set_source(order[i], 1'b0);
            wait_on(1'b1, n);
            lo = order[i] == SRC_MCD ? 1990 : 2001;
            hi = order[i] inside {SRC_PIN, SRC_SUPPLY, SRC_MCD} ? 2005 : 2001;
            if (order[i] == SRC_POR)
            begin
                lo = (POR_T - 1) * 40;
                hi = POR_T * 40 + 12;
            end
            check_count(n, lo, hi, "release");
            check_exit;
        end
        // a new source during the delay restarts it
        sw_req = 1'b1;
        repeat (4) @(negedge clock);
        sw_req = 1'b0;
        repeat (1000) @(negedge clock);
        wdt_req = 1'b1;
        @(negedge clock);
        wdt_req = 1'b0;
        wait_on(1'b1, n);
        check_count(n, 2001, 2001, "restart");
        check_vec({8'h00, reset_cause}, 16'h0028, "sticky");
        check_exit;
        tally_and_finish;
    end
endmodule
